// *** src/ssaw_defines.svh ***
// Purpose : Named constants for the synchronous SRAM address and write front end
// Assumes : Included by its bare name from every design file
// Notes   : Definitions only
`ifndef SSAW_DEFINES_SVH
`define SSAW_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define SSAW_ADDR_W        19
`define SSAW_LANES         4
`define SSAW_LANE_W        9
`define SSAW_BURST_W       2
`define SSAW_BURST_LSB     0
`define SSAW_LANE_PAR_BIT  8

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define SSAW_BURST_RST     2'h0
`define SSAW_BURST_ONE     2'h1
`define SSAW_LANES_NONE    4'h0
`define SSAW_LANES_ALL     4'hf

`endif

// *** src/ssaw_pkg.sv ***
// Purpose : Types shared by the SRAM front end modules
// Assumes : ssaw_defines.svh supplies the widths
// Notes   : Structs carry grouped pin samples and state
`include "ssaw_defines.svh"

package ssaw_pkg;

  // ----------------------------------------------------------------
  // Sampled bus controls
  // ----------------------------------------------------------------
  typedef struct packed {
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic chip_sel1_n;
    logic chip_sel2;
    logic chip_sel3_n;
    logic byte_write_enable_n;
    logic global_write_n;
    logic [`SSAW_LANES-1:0] lane_write_sel_n;
  } ssaw_ctrl_t;

  // Capture cause
  typedef enum logic [1:0] {
    SSAW_CAP_NONE = 2'h0,
    SSAW_CAP_PROC = 2'h1,
    SSAW_CAP_CTRL = 2'h2
  } ssaw_cap_t;

  // Burst state
  typedef enum logic [0:0] {
    SSAW_IDLE  = 1'h0,
    SSAW_BURST = 1'h1
  } ssaw_state_t;

endpackage

// *** src/ssaw_burst_seq.sv ***
// Purpose : Burst counter and low address pair generator
// Assumes : Single clock, synchronous active low reset
// Notes   : Order select is a static strap, sampled by the caller
`include "ssaw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ssaw_burst_seq
  import ssaw_pkg::*;
(
  input  wire logic                     SYS_CLK,
  input  wire logic                     NRST,
  input  wire logic                     load,
  input  wire logic [`SSAW_BURST_W-1:0] start_pair,
  input  wire logic                     advance,
  input  wire logic                     interleaved,
  output logic      [`SSAW_BURST_W-1:0] low_pair,
  output logic      [`SSAW_BURST_W-1:0] beat
);

  typedef struct packed {
    logic [`SSAW_BURST_W-1:0] start_ff;
    logic [`SSAW_BURST_W-1:0] beat_ff;
    logic [`SSAW_BURST_W-1:0] pair_ff;
  } ssaw_seq_st_t;

  ssaw_seq_st_t st_ff;
  ssaw_seq_st_t nxt_st;
  logic [`SSAW_BURST_W-1:0] nxt_beat;

  // Next count and next low pair; count wraps after four beats
  always_comb begin
    nxt_st   = st_ff;
    nxt_beat = `SSAW_BURST_RST;
    if (load) begin
      nxt_st.start_ff = start_pair;
      nxt_st.beat_ff  = `SSAW_BURST_RST;
      nxt_st.pair_ff  = start_pair;
    end else if (advance) begin
      nxt_beat       = st_ff.beat_ff + `SSAW_BURST_ONE;
      nxt_st.beat_ff = nxt_beat;
      if (interleaved) begin
        nxt_st.pair_ff = st_ff.start_ff ^ nxt_beat;
      end else begin
        nxt_st.pair_ff = st_ff.start_ff + nxt_beat;
      end
    end
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign low_pair = st_ff.pair_ff;
  assign beat     = st_ff.beat_ff;

endmodule

`default_nettype wire

// *** src/ssaw_front.sv ***
// Purpose : Address capture, burst control and byte lane write decode
// Assumes : Bus master drives all pins on SYS_CLK; every pin is still double synchronised
// Notes   : Outputs follow the sampled pins by the synchroniser depth plus one edge
`include "ssaw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ssaw_front
  import ssaw_pkg::*;
#(
  parameter int ADDR_W = `SSAW_ADDR_W,
  parameter int LANES  = `SSAW_LANES,
  parameter int LANE_W = `SSAW_LANE_W
) (
  input  wire logic                    SYS_CLK,
  input  wire logic                    NRST,
  input  wire logic [ADDR_W-1:0]       ADDR,
  input  wire logic                    PROC_ADDR_STROBE_N,
  input  wire logic                    CTRL_ADDR_STROBE_N,
  input  wire logic                    BURST_ADVANCE_N,
  input  wire logic                    CHIP_SEL1_N,
  input  wire logic                    CHIP_SEL2,
  input  wire logic                    CHIP_SEL3_N,
  input  wire logic [LANES-1:0]        LANE_WRITE_SEL_N,
  input  wire logic                    BYTE_WRITE_ENABLE_N,
  input  wire logic                    GLOBAL_WRITE_N,
  input  wire logic                    BURST_ORDER,
  input  wire logic [LANES*LANE_W-1:0] WRITE_DATA,
  output logic      [ADDR_W-1:0]       MEM_ADDR,
  output logic                         ADDR_VALID,
  output logic      [1:0]              CAPTURE_CAUSE,
  output logic      [LANES-1:0]        LANE_WRITE,
  output logic      [LANES*LANE_W-1:0] LANE_DATA,
  output logic      [1:0]              BURST_BEAT
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W <= `SSAW_BURST_W) begin : g_bad_addr
    $error("ADDR_W must exceed the burst counter width");
  end
  if (LANE_W != `SSAW_LANE_W) begin : g_bad_lane
    $error("LANE_W must be eight data bits plus parity");
  end
  if (LANES < 1) begin : g_bad_lanes
    $error("LANES must be at least one");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ssaw_ctrl_t              ctrl_raw;
  ssaw_ctrl_t              ctrl_m_ff;
  ssaw_ctrl_t              ctrl_s_ff;
  logic [ADDR_W-1:0]       addr_m_ff;
  logic [ADDR_W-1:0]       addr_s_ff;
  logic [LANES*LANE_W-1:0] data_m_ff;
  logic [LANES*LANE_W-1:0] data_s_ff;
  logic                    order_m_ff;
  logic                    order_s_ff;

  assign ctrl_raw = '{proc_addr_strobe_n:  PROC_ADDR_STROBE_N,
                      ctrl_addr_strobe_n:  CTRL_ADDR_STROBE_N,
                      burst_advance_n:     BURST_ADVANCE_N,
                      chip_sel1_n:         CHIP_SEL1_N,
                      chip_sel2:           CHIP_SEL2,
                      chip_sel3_n:         CHIP_SEL3_N,
                      byte_write_enable_n: BYTE_WRITE_ENABLE_N,
                      global_write_n:      GLOBAL_WRITE_N,
                      lane_write_sel_n:    LANE_WRITE_SEL_N};

  // Two stages before any logic; rising edge only, control pins and strap idle high at reset, address and data low
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ctrl_m_ff  <= '1;
      ctrl_s_ff  <= '1;
      addr_m_ff  <= '0;
      addr_s_ff  <= '0;
      data_m_ff  <= '0;
      data_s_ff  <= '0;
      order_m_ff <= 1'h1;
      order_s_ff <= 1'h1;
    end else begin
      ctrl_m_ff  <= ctrl_raw;
      ctrl_s_ff  <= ctrl_m_ff;
      addr_m_ff  <= ADDR;
      addr_s_ff  <= addr_m_ff;
      data_m_ff  <= WRITE_DATA;
      data_s_ff  <= data_m_ff;
      order_m_ff <= BURST_ORDER;
      order_s_ff <= order_m_ff;
    end
  end

  // ----------------------------------------------------------------
  // Capture decode
  // ----------------------------------------------------------------
  // Called only by the capture decode
  function automatic logic chip_active(input ssaw_ctrl_t c);
    return !c.chip_sel1_n && c.chip_sel2 && !c.chip_sel3_n;
  endfunction

  ssaw_cap_t cap;
  logic      chip_on;

  // Processor strobe has priority; it is dropped when sel1 is high,
  // while the controller strobe still needs all enables active
  always_comb begin
    chip_on = chip_active(ctrl_s_ff);
    cap     = SSAW_CAP_NONE;
    if (!ctrl_s_ff.proc_addr_strobe_n && !ctrl_s_ff.chip_sel1_n) begin
      if (chip_on) begin
        cap = SSAW_CAP_PROC;
      end
    end else if (!ctrl_s_ff.ctrl_addr_strobe_n && chip_on) begin
      cap = SSAW_CAP_CTRL;
    end
  end

  // ----------------------------------------------------------------
  // Front end state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssaw_state_t             state_ff;
    logic [ADDR_W-1:0]       addr_ff;
    logic                    valid_ff;
    ssaw_cap_t               cause_ff;
    logic [LANES-1:0]        lane_wr_ff;
    logic [LANES*LANE_W-1:0] data_ff;
  } ssaw_front_st_t;

  ssaw_front_st_t st_ff;
  ssaw_front_st_t nxt_st;
  logic [`SSAW_BURST_W-1:0] low_pair;
  logic [LANES-1:0]         lane_sel;
  logic                     advance;

  assign advance = (st_ff.state_ff == SSAW_BURST) && !ctrl_s_ff.burst_advance_n &&
                   (cap == SSAW_CAP_NONE);

  // Per lane write strobe; global write overrides selects and byte enable
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_sel[i] = !ctrl_s_ff.global_write_n ||
                         (!ctrl_s_ff.byte_write_enable_n &&
                          !ctrl_s_ff.lane_write_sel_n[i]);
  end

  // Next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.valid_ff = 1'h0;
    nxt_st.cause_ff = cap;
    if (cap != SSAW_CAP_NONE) begin
      nxt_st.state_ff = SSAW_BURST;
      nxt_st.addr_ff  = addr_s_ff;
      nxt_st.valid_ff = 1'h1;
    end else if (advance) begin
      nxt_st.valid_ff = 1'h1;
    end
    // Writes only land on a capture or burst advance cycle
    if (nxt_st.valid_ff) begin
      nxt_st.lane_wr_ff = lane_sel;
    end else begin
      nxt_st.lane_wr_ff = `SSAW_LANES_NONE;
    end
    nxt_st.data_ff = data_s_ff;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      st_ff <= '{state_ff: SSAW_IDLE, cause_ff: SSAW_CAP_NONE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------
  // Strap sampled through synchroniser; it must stay static anyway
  ssaw_burst_seq u_seq (
    .SYS_CLK     (SYS_CLK),
    .NRST        (NRST),
    .load        (cap != SSAW_CAP_NONE),
    .start_pair  (addr_s_ff[`SSAW_BURST_LSB +: `SSAW_BURST_W]),
    .advance     (advance),
    .interleaved (order_s_ff),
    .low_pair    (low_pair),
    .beat        (BURST_BEAT)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Low pair comes from the counter so bursts walk without new addresses.
  // A pin sampled at one edge reaches these outputs three edges later:
  // the price of synchronising every pin, which the far side must plan for.
  // Strobes stand for one cycle only, so a consumer must take them as they
  // appear; address and beat hold until the next capture or advance.
  assign MEM_ADDR      = {st_ff.addr_ff[ADDR_W-1:`SSAW_BURST_W], low_pair};
  assign ADDR_VALID    = st_ff.valid_ff;
  assign CAPTURE_CAUSE = st_ff.cause_ff;
  assign LANE_WRITE    = st_ff.lane_wr_ff;
  assign LANE_DATA     = st_ff.data_ff;      // lane i owns bits i*9 .. i*9+8, parity on top

endmodule

`default_nettype wire

// *** tb/ssaw_front_monitor.sv ***
// Purpose: Port checker for the SRAM front end
// Assumes: Outputs follow sampled pins by three clock edges
// Notes: Bound into every ssaw_front instance
`timescale 1ns/1ps
`default_nettype none
module ssaw_front_monitor #(
  parameter int ADDR_W = 19,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  input wire logic                    SYS_CLK,
  input wire logic                    NRST,
  input wire logic [ADDR_W-1:0]       ADDR,
  input wire logic                    PROC_ADDR_STROBE_N,
  input wire logic                    CTRL_ADDR_STROBE_N,
  input wire logic                    BURST_ADVANCE_N,
  input wire logic                    CHIP_SEL1_N,
  input wire logic                    CHIP_SEL2,
  input wire logic                    CHIP_SEL3_N,
  input wire logic [LANES-1:0]        LANE_WRITE_SEL_N,
  input wire logic                    BYTE_WRITE_ENABLE_N,
  input wire logic                    GLOBAL_WRITE_N,
  input wire logic                    BURST_ORDER,
  input wire logic [LANES*LANE_W-1:0] WRITE_DATA,
  input wire logic [ADDR_W-1:0]       MEM_ADDR,
  input wire logic                    ADDR_VALID,
  input wire logic [1:0]              CAPTURE_CAUSE,
  input wire logic [LANES-1:0]        LANE_WRITE,
  input wire logic [LANES*LANE_W-1:0] LANE_DATA,
  input wire logic [1:0]              BURST_BEAT
);
  // ----------------------------------------------------------------
  // Capture terms, delayed by $past to line up with the outputs
  // ----------------------------------------------------------------
  logic              en;
  logic              capp;
  logic              cap;
  logic [1:0]        lo;
  logic [ADDR_W-3:0] hi;
  assign en   = !CHIP_SEL1_N && CHIP_SEL2 && !CHIP_SEL3_N;
  assign capp = !PROC_ADDR_STROBE_N && en;
  assign cap  = (!PROC_ADDR_STROBE_N || !CTRL_ADDR_STROBE_N) && en;
  assign lo   = MEM_ADDR[1:0];
  assign hi   = MEM_ADDR[ADDR_W-1:2];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // Guarded by past reset so pins sampled in reset never count
  a_proc_capture: assert property ($past(NRST, 3) && $past(capp, 3) |->
    ADDR_VALID && CAPTURE_CAUSE == 2'h1 && BURST_BEAT == 2'h0) else $error("proc capture wrong");
  a_ctrl_capture: assert property ($past(NRST, 3) && $past(cap, 3) && !$past(capp, 3) |->
    ADDR_VALID && CAPTURE_CAUSE == 2'h2) else $error("ctrl capture wrong");
  a_disabled_ignored: assert property ($past(NRST, 3) && !$past(en, 3) && $past(BURST_ADVANCE_N, 3) |->
    !ADDR_VALID) else $error("capture while deselected");
  a_addr_load: assert property ($past(NRST, 3) && $past(cap, 3) |->
    MEM_ADDR == $past(ADDR, 3)) else $error("captured address wrong");
  a_global_all: assert property ($past(NRST, 3) && $past(cap, 3) && !$past(GLOBAL_WRITE_N, 3) |->
    LANE_WRITE == 4'hf) else $error("global write lanes wrong");
  a_byte_lanes: assert property ($past(NRST, 3) && $past(cap, 3) && $past(GLOBAL_WRITE_N, 3) |->
    LANE_WRITE == ($past(BYTE_WRITE_ENABLE_N, 3) ? 4'h0 : ~$past(LANE_WRITE_SEL_N, 3))) else $error("byte lanes wrong");
  a_data_copy: assert property ($past(NRST, 3) |-> LANE_DATA == $past(WRITE_DATA, 3))
    else $error("lane data wrong");
  a_beat_step: assert property ($past(NRST) && ADDR_VALID && CAPTURE_CAUSE == 2'h0 |->
    BURST_BEAT == $past(BURST_BEAT) + 2'h1 && hi == $past(hi) &&
    lo == (BURST_ORDER ? $past(lo) ^ $past(BURST_BEAT) ^ BURST_BEAT : $past(lo) + 2'h1)) else $error("burst step wrong");
  a_beat_hold: assert property ($past(NRST) && !ADDR_VALID |->
    $stable(BURST_BEAT) && $stable(MEM_ADDR)) else $error("burst state moved");
endmodule
bind ssaw_front ssaw_front_monitor #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) mon_u (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .PROC_ADDR_STROBE_N(PROC_ADDR_STROBE_N),
  .CTRL_ADDR_STROBE_N(CTRL_ADDR_STROBE_N), .BURST_ADVANCE_N(BURST_ADVANCE_N), .CHIP_SEL1_N(CHIP_SEL1_N),
  .CHIP_SEL2(CHIP_SEL2), .CHIP_SEL3_N(CHIP_SEL3_N), .LANE_WRITE_SEL_N(LANE_WRITE_SEL_N),
  .BYTE_WRITE_ENABLE_N(BYTE_WRITE_ENABLE_N), .GLOBAL_WRITE_N(GLOBAL_WRITE_N), .BURST_ORDER(BURST_ORDER),
  .WRITE_DATA(WRITE_DATA), .MEM_ADDR(MEM_ADDR), .ADDR_VALID(ADDR_VALID), .CAPTURE_CAUSE(CAPTURE_CAUSE),
  .LANE_WRITE(LANE_WRITE), .LANE_DATA(LANE_DATA), .BURST_BEAT(BURST_BEAT));
`default_nettype wire

// *** tb/ssaw_bus_model.sv ***
// Purpose: Processor side driving the SRAM bus pins
// Assumes: Caller invokes its tasks at the falling clock edge
// Notes: Lines not in use toggle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module ssaw_bus_model
  import ssaw_pkg::*;
(
  output var ssaw_ctrl_t  ctrl,
  output logic [18:0]     addr,
  output logic [35:0]     wdata
);
  // Idle pins: strobes and advance high, chip enabled
  initial begin
    ctrl  = 12'hebf;
    addr  = 19'h0;
    wdata = 36'h0;
  end
  // Set half a cycle early and held a full cycle around the edge
  task put(input ssaw_ctrl_t c, input logic [18:0] a, input logic [35:0] d);
    ctrl  = c;
    addr  = a;
    wdata = d;
  endtask
  // Released lines show the inverse, not the last value
  task idle();
    ctrl  = 12'hebf;
    addr  = ~addr;
    wdata = ~wdata;
  endtask
endmodule
`default_nettype wire

// *** tb/sync_sram_addr_write_ctrl_tb.sv ***
// Purpose: Self-checking bench for the SRAM front end
// Assumes: Three edge pipeline from pin to output
// Notes: Scenarios fill an op table that run_seq plays back to back
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module sync_sram_addr_write_ctrl_tb
  import ssaw_pkg::*;
;
  logic        sys_clk, nrst, order, valid;
  ssaw_ctrl_t  c;
  logic [18:0] a, mem_addr;
  logic [35:0] d, lane_data;
  logic [1:0]  cause, beat;
  logic [3:0]  lanes;
  int          miscompares, compares;
  ssaw_ctrl_t  oc[8];
  logic [18:0] oa[8];
  logic        ev[8];
  logic [1:0]  ec[8], eb[8];
  logic [3:0]  el[8];
  ssaw_front dut_u (.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(a), .PROC_ADDR_STROBE_N(c.proc_addr_strobe_n),
    .CTRL_ADDR_STROBE_N(c.ctrl_addr_strobe_n), .BURST_ADVANCE_N(c.burst_advance_n), .CHIP_SEL1_N(c.chip_sel1_n),
    .CHIP_SEL2(c.chip_sel2), .CHIP_SEL3_N(c.chip_sel3_n), .LANE_WRITE_SEL_N(c.lane_write_sel_n),
    .BYTE_WRITE_ENABLE_N(c.byte_write_enable_n), .GLOBAL_WRITE_N(c.global_write_n), .BURST_ORDER(order),
    .WRITE_DATA(d), .MEM_ADDR(mem_addr), .ADDR_VALID(valid), .CAPTURE_CAUSE(cause), .LANE_WRITE(lanes),
    .LANE_DATA(lane_data), .BURST_BEAT(beat));
  ssaw_bus_model mst_u (.ctrl(c), .addr(a), .wdata(d));
  always #12.5 sys_clk = ~sys_clk;
  task close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Order strap only moves while reset is held
  task do_reset(input logic o);
    @(negedge sys_clk);
    nrst  = 1'b0;
    order = o;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
  endtask
  task op(input int i, input ssaw_ctrl_t k, input logic [18:0] x, input logic v, input logic [1:0] s,
          input logic [3:0] l, input logic [1:0] b);
    oc[i] = k; oa[i] = x; ev[i] = v; ec[i] = s; el[i] = l; eb[i] = b;
  endtask
  // Drive one op per cycle; op j shows three falling edges later
  task run_seq(input int n);
    for (int i = 0; i < n + 3; i++) begin
      @(negedge sys_clk);
      if (i >= 3) begin
        `CHK("valid", ev[i-3], valid)
        `CHK("lanes", el[i-3], lanes)
        if (ev[i-3]) begin
          `CHK("cause", ec[i-3], cause)
          `CHK("addr", oa[i-3], mem_addr)
          `CHK("beat", eb[i-3], beat)
          `CHK("data", {oa[i-3][17:0], ~oa[i-3][17:0]}, lane_data)
        end
      end
      // Advance beats put the inverse on the address pins to catch a false capture
      if (i < n)
        mst_u.put(oc[i], oc[i].burst_advance_n ? oa[i] : ~oa[i], {oa[i][17:0], ~oa[i][17:0]});
      else
        mst_u.idle();
    end
  endtask
  task t_capture();
    op(0, 12'h6af, 19'h5a5a5, 1'b1, 2'h1, 4'hf, 2'h0);
    for (int k = 0; k < 4; k++)
      op(k + 1, {8'ha9, ~(4'h1 << k)}, 19'h12340 + 19'(k), 1'b1, 2'h2, 4'h1 << k, 2'h0);
    op(5, 12'hab0, 19'h0f0f3, 1'b1, 2'h2, 4'h0, 2'h0);
    op(6, 12'h2bf, 19'h33332, 1'b1, 2'h1, 4'h0, 2'h0);
    run_seq(7);
    $display("t_capture done");
  endtask
  task t_refuse();
    op(0, 12'ha3f, 19'h11111, 1'b0, 2'h0, 4'h0, 2'h0);
    op(1, 12'haff, 19'h22222, 1'b0, 2'h0, 4'h0, 2'h0);
    op(2, 12'h7bf, 19'h44444, 1'b0, 2'h0, 4'h0, 2'h0);
    op(3, 12'h3bf, 19'h55555, 1'b0, 2'h0, 4'h0, 2'h0);
    run_seq(4);
    $display("t_refuse done");
  endtask
  // Start pair 1 gives different linear and interleaved sequences
  task t_burst(input logic o);
    logic [1:0] b;
    do_reset(o);
    op(0, 12'h6bf, 19'h7ff01, 1'b1, 2'h1, 4'h0, 2'h0);
    for (int k = 1; k < 7; k++) begin
      b = (k < 4) ? 2'(k) : 2'(k - 1);
      op(k, k == 4 ? 12'hebf : (k == 6 ? 12'hcbf : 12'hcaf), {17'h1ffc0, o ? 2'h1 ^ b : 2'h1 + b},
         k != 4, 2'h0, (k == 4 || k == 6) ? 4'h0 : 4'hf, b);
    end
    run_seq(7);
    $display("t_burst done");
  endtask
  initial begin
    sys_clk     = 1'b0;
    nrst        = 1'b0;
    order       = 1'b1;
    miscompares = 0;
    compares    = 0;
    do_reset(1'b1);
    t_capture();
    t_refuse();
    t_burst(1'b0);
    t_burst(1'b1);
    close_out();
  end
  // Guard against a hung run
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
